// File: design/mlps_pkg.sv
// constants, register map and strap mapping for the mac lane mode / power strap block
// assumes a single 40 MHz core clock domain and an AHB-Lite register port
// Operation
// - one mode strap per MAC 0, 2, 4, 6 sets all four of its ports
// - mode strap 0 runs the MAC as one four-lane port, three ports unused
// - mode strap 1 runs the MAC as four independent single-lane ports
// - software mode override field wins over the mode strap
// - four-lane mode: primary power-down governs all four SerDes lanes
// - single-lane mode: each secondary port follows its own power-down
// - single-lane mode: SerDes off once all four ports are powered down
// - primary port x shares its MAC with ports x+1, x+8, x+9
// - primary power-down straps on ports 2, 4, 6; 1 means powered down
// - secondary power-down straps on ports 1,3,5,7..15; 1 means powered down
// - secondary ports carry no traffic in four-lane mode, held powered down
// - software wide power-down override wins over the primary power-down strap
// - strap pin drivers enabled only in test mode, inputs otherwise
package mlps_pkg;

    localparam int MAC_N   = 4;
    localparam int PORT_N  = 16;
    localparam int PRI_N   = 3;
    localparam int SEC_N   = 12;
    localparam int ADDR_W  = 8;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_MODE_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_WIDE_PD   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_PORT_PD   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STRAP_ST  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_EFFECT_ST = 8'h10;

    // field positions
    localparam int MODE_EN_LSB  = 0;
    localparam int MODE_VAL_LSB = 8;
    localparam int WPD_EN_LSB   = 0;
    localparam int WPD_VAL_LSB  = 8;
    localparam int PPD_EN_LSB   = 0;
    localparam int PPD_VAL_LSB  = 16;
    localparam int ST_MODE_LSB  = 0;
    localparam int ST_PD_LSB    = 8;
    localparam int ST_DONE_BIT  = 31;
    localparam int EF_MODE_LSB  = 0;
    localparam int EF_SPD_LSB   = 4;
    localparam int EF_PPD_LSB   = 16;

    // ports that own a per-port override bit (secondaries only)
    localparam logic [PORT_N-1:0] PPD_MASK = 16'hFFAA;

    // reset values
    localparam logic [MAC_N-1:0]  MAC_RST       = 4'h0;
    localparam logic [PORT_N-1:0] PORT_RST      = 16'h0000;
    localparam logic [PORT_N-1:0] PORT_PD_RST   = 16'hFFFF;
    localparam logic [MAC_N-1:0]  SERDES_PD_RST = 4'hF;
    localparam logic [31:0]       WORD_RST      = 32'h0000_0000;

    // cycles after reset release before the synchronised straps are taken
    localparam logic [3:0] SETTLE_CYCLES = 4'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [0:0] {
        ST_SETTLE = 1'b0,
        ST_HELD   = 1'b1
    } mlps_state_t;

    // pin groups to a 16-port vector; port 0 has no strap and reads as up
    function automatic logic [PORT_N-1:0] strap_to_ports(input logic [PRI_N-1:0] pri,
                                                        input logic [SEC_N-1:0] sec);
        strap_to_ports = {sec[11:3], pri[2], sec[2], pri[1], sec[1], pri[0], sec[0], 1'b0};
    endfunction

endpackage

// File: design/mlps_sync.sv
// two-flop synchroniser for a bundle of slow strap and mode pins
// assumes each bit is a static level; bits are not coherent as a word
`timescale 1ns/1ps
`default_nettype none
module mlps_sync #(
    parameter int W = 1
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= din;
            sync_ff <= meta_ff;
        end
    end

    assign dout = sync_ff;
endmodule
`default_nettype wire

// File: design/mlps_mac_power.sv
// power-down resolution for one MAC: one primary and three secondary ports
// purely combinational; the caller registers the results
`timescale 1ns/1ps
`default_nettype none
module mlps_mac_power (
    input  wire logic       single_lane,
    input  wire logic [3:0] pd_req,
    output logic      [3:0] port_pd,
    output logic            serdes_pd
);
    // lane order: primary, x+1, x+8, x+9
    wire [3:0] wide_pd   = {3'b111, pd_req[0]};
    wire [3:0] narrow_pd = pd_req;

    assign port_pd   = single_lane ? narrow_pd : wide_pd;
    assign serdes_pd = single_lane ? (&pd_req) : pd_req[0];
endmodule
`default_nettype wire

// File: design/mlps_top.sv
// mac lane mode and power strap block with AHB-Lite register port
// assumes straps are board tie-offs, stable from power-up, and one core clock
`timescale 1ns/1ps
`default_nettype none
module mlps_top #(
    parameter int MAC_N  = mlps_pkg::MAC_N,
    parameter int PORT_N = mlps_pkg::PORT_N
) (
    input  wire logic                        hclk,
    input  wire logic                        hresetn,
    input  wire logic                        hsel,
    input  wire logic [mlps_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                  htrans,
    input  wire logic                        hwrite,
    input  wire logic [2:0]                  hsize,
    input  wire logic [31:0]                 hwdata,
    input  wire logic                        hready,
    output logic      [31:0]                 hrdata,
    output logic                             hreadyout,
    output logic                             hresp,
    input  wire logic                        test_mode,
    input  wire logic [MAC_N-1:0]            override_a_strap_i,
    output logic      [MAC_N-1:0]            override_a_strap_o,
    output logic      [MAC_N-1:0]            override_a_strap_oe,
    input  wire logic [mlps_pkg::PRI_N-1:0]  primary_port_powerdown_strap_i,
    output logic      [mlps_pkg::PRI_N-1:0]  primary_port_powerdown_strap_o,
    output logic      [mlps_pkg::PRI_N-1:0]  primary_port_powerdown_strap_oe,
    input  wire logic [mlps_pkg::SEC_N-1:0]  secondary_port_powerdown_strap_i,
    output logic      [mlps_pkg::SEC_N-1:0]  secondary_port_powerdown_strap_o,
    output logic      [mlps_pkg::SEC_N-1:0]  secondary_port_powerdown_strap_oe,
    output logic      [MAC_N-1:0]            mac_single_lane,
    output logic      [PORT_N-1:0]           port_powerdown,
    output logic      [MAC_N-1:0]            serdes_powerdown,
    output logic                             powerup_sampled
);
    localparam int SYNC_W = 1 + MAC_N + mlps_pkg::PRI_N + mlps_pkg::SEC_N;

    // pin synchronisation
    wire [SYNC_W-1:0] pins_sync;
    mlps_sync #(.W(SYNC_W)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .din     ({test_mode, override_a_strap_i, primary_port_powerdown_strap_i,
                   secondary_port_powerdown_strap_i}),
        .dout    (pins_sync)
    );

    wire                       test_sync = pins_sync[SYNC_W-1];
    wire [MAC_N-1:0]           mode_sync = pins_sync[SYNC_W-2 -: MAC_N];
    wire [mlps_pkg::PRI_N-1:0] pri_sync  = pins_sync[mlps_pkg::SEC_N +: mlps_pkg::PRI_N];
    wire [mlps_pkg::SEC_N-1:0] sec_sync  = pins_sync[mlps_pkg::SEC_N-1:0];

    // strap capture sequencer
    mlps_pkg::mlps_state_t state_ff;
    mlps_pkg::mlps_state_t nxt_state;
    logic [3:0]      settle_ff;
    logic [3:0]      nxt_settle;
    logic [MAC_N-1:0]  cap_mode_ff;
    logic [MAC_N-1:0]  cap_mode_pins_ff;
    logic [PORT_N-1:0] cap_pd_ff;
    logic [mlps_pkg::PRI_N-1:0] cap_pri_ff;
    logic [mlps_pkg::SEC_N-1:0] cap_sec_ff;

    wire settle_done = (settle_ff == mlps_pkg::SETTLE_CYCLES - 4'h1);
    wire capture     = (state_ff == mlps_pkg::ST_SETTLE) && settle_done;
    wire held        = (state_ff == mlps_pkg::ST_HELD);

    always_comb begin
        nxt_state  = state_ff;
        nxt_settle = settle_ff;
        case (state_ff)
            mlps_pkg::ST_SETTLE: begin
                nxt_settle = settle_ff + 4'h1;
                if (settle_done) begin
                    nxt_state = mlps_pkg::ST_HELD;
                end
            end
            mlps_pkg::ST_HELD: begin
                nxt_settle = settle_ff;
            end
            default: begin
                nxt_state  = mlps_pkg::ST_SETTLE;
                nxt_settle = 4'h0;
            end
        endcase
    end

    // sampled once only; no later strap pin movement reaches the core
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff  <= mlps_pkg::ST_SETTLE;
            settle_ff <= 4'h0;
        end else begin
            state_ff  <= nxt_state;
            settle_ff <= nxt_settle;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_mode_ff      <= mlps_pkg::MAC_RST;
            cap_mode_pins_ff <= mlps_pkg::MAC_RST;
            cap_pd_ff        <= mlps_pkg::PORT_RST;
            cap_pri_ff       <= '0;
            cap_sec_ff       <= '0;
        end else if (capture) begin
            cap_mode_ff      <= mode_sync;
            cap_mode_pins_ff <= mode_sync;
            cap_pd_ff        <= mlps_pkg::strap_to_ports(pri_sync, sec_sync);
            cap_pri_ff       <= pri_sync;
            cap_sec_ff       <= sec_sync;
        end
    end

    // AHB-Lite slave: zero wait states, always OKAY
    logic                        wr_pend_ff;
    logic [mlps_pkg::ADDR_W-1:0] wr_addr_ff;
    logic [31:0]                 hrdata_ff;
    logic [MAC_N-1:0]            mode_en_ff;
    logic [MAC_N-1:0]            mode_val_ff;
    logic [MAC_N-1:0]            wpd_en_ff;
    logic [MAC_N-1:0]            wpd_val_ff;
    logic [PORT_N-1:0]           ppd_en_ff;
    logic [PORT_N-1:0]           ppd_val_ff;

    wire access = hsel && hready && htrans[1];
    wire word_ok = (hsize == mlps_pkg::HSIZE_WORD) && (haddr[1:0] == 2'b00);
    wire rd_take = access && !hwrite;
    // sub-word and misaligned writes are dropped, reads answer zero
    wire wr_take = access && hwrite && word_ok;

    wire wr_mode = wr_pend_ff && (wr_addr_ff == mlps_pkg::OFF_MODE_CTRL);
    wire wr_wpd  = wr_pend_ff && (wr_addr_ff == mlps_pkg::OFF_WIDE_PD);
    wire wr_ppd  = wr_pend_ff && (wr_addr_ff == mlps_pkg::OFF_PORT_PD);

    logic [MAC_N-1:0]  single_ff;
    logic [PORT_N-1:0] port_pd_ff;
    logic [MAC_N-1:0]  serdes_pd_ff;
    logic              sampled_ff;

    wire [31:0] rd_mode = {20'h0, mode_val_ff, 4'h0, mode_en_ff};
    wire [31:0] rd_wpd  = {20'h0, wpd_val_ff, 4'h0, wpd_en_ff};
    wire [31:0] rd_ppd  = {ppd_val_ff, ppd_en_ff};
    wire [31:0] rd_st   = {sampled_ff, 7'h0, cap_pd_ff, 4'h0, cap_mode_ff};
    wire [31:0] rd_ef   = {port_pd_ff, 8'h0, serdes_pd_ff, single_ff};

    wire [31:0] rd_mux =
        !word_ok                               ? mlps_pkg::WORD_RST :
        (haddr == mlps_pkg::OFF_MODE_CTRL)  ? rd_mode :
        (haddr == mlps_pkg::OFF_WIDE_PD)    ? rd_wpd  :
        (haddr == mlps_pkg::OFF_PORT_PD)    ? rd_ppd  :
        (haddr == mlps_pkg::OFF_STRAP_ST)   ? rd_st   :
        (haddr == mlps_pkg::OFF_EFFECT_ST)  ? rd_ef   : mlps_pkg::WORD_RST;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            wr_addr_ff <= '0;
            hrdata_ff  <= mlps_pkg::WORD_RST;
        end else begin
            wr_pend_ff <= wr_take;
            if (wr_take) begin
                wr_addr_ff <= haddr;
            end
            if (rd_take) begin
                hrdata_ff <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_en_ff  <= mlps_pkg::MAC_RST;
            mode_val_ff <= mlps_pkg::MAC_RST;
            wpd_en_ff   <= mlps_pkg::MAC_RST;
            wpd_val_ff  <= mlps_pkg::MAC_RST;
            ppd_en_ff   <= mlps_pkg::PORT_RST;
            ppd_val_ff  <= mlps_pkg::PORT_RST;
        end else begin
            if (wr_mode) begin
                mode_en_ff  <= hwdata[mlps_pkg::MODE_EN_LSB +: MAC_N];
                mode_val_ff <= hwdata[mlps_pkg::MODE_VAL_LSB +: MAC_N];
            end
            if (wr_wpd) begin
                wpd_en_ff  <= hwdata[mlps_pkg::WPD_EN_LSB +: MAC_N];
                wpd_val_ff <= hwdata[mlps_pkg::WPD_VAL_LSB +: MAC_N];
            end
            if (wr_ppd) begin
                ppd_en_ff  <= hwdata[mlps_pkg::PPD_EN_LSB +: PORT_N] & mlps_pkg::PPD_MASK;
                ppd_val_ff <= hwdata[mlps_pkg::PPD_VAL_LSB +: PORT_N] & mlps_pkg::PPD_MASK;
            end
        end
    end

    // effective mode and power-down requests
    wire [MAC_N-1:0] eff_mode = (mode_en_ff & mode_val_ff) | (~mode_en_ff & cap_mode_ff);
    logic [PORT_N-1:0] pd_req;
    logic [PORT_N-1:0] nxt_port_pd;
    logic [MAC_N-1:0]  nxt_serdes_pd;

    genvar k;
    generate
        for (k = 0; k < MAC_N; k++) begin : g_mac
            localparam int P = 2 * k;
            wire [3:0] lanes_pd;
            // primary request: wide override before strap
            assign pd_req[P] = wpd_en_ff[k] ? wpd_val_ff[k] : cap_pd_ff[P];
            assign pd_req[P+1] = ppd_en_ff[P+1] ? ppd_val_ff[P+1] : cap_pd_ff[P+1];
            assign pd_req[P+8] = ppd_en_ff[P+8] ? ppd_val_ff[P+8] : cap_pd_ff[P+8];
            assign pd_req[P+9] = ppd_en_ff[P+9] ? ppd_val_ff[P+9] : cap_pd_ff[P+9];

            mlps_mac_power u_pwr (
                .single_lane (eff_mode[k]),
                .pd_req      ({pd_req[P+9], pd_req[P+8], pd_req[P+1], pd_req[P]}),
                .port_pd     (lanes_pd),
                .serdes_pd   (nxt_serdes_pd[k])
            );
            assign nxt_port_pd[P]   = lanes_pd[0];
            assign nxt_port_pd[P+1] = lanes_pd[1];
            assign nxt_port_pd[P+8] = lanes_pd[2];
            assign nxt_port_pd[P+9] = lanes_pd[3];

            a_mode_select: assert property (@(posedge hclk) disable iff (!hresetn)
                held && $past(held) |-> single_ff[k] ==
                    ($past(mode_en_ff[k]) ? $past(mode_val_ff[k]) : $past(cap_mode_ff[k])))
                else $error("override_a does not follow override or strap");
            a_strap_mode: assert property (@(posedge hclk) disable iff (!hresetn)
                held && $past(held) && !$past(mode_en_ff[k]) |->
                    single_ff[k] == cap_mode_pins_ff[k])
                else $error("override_a differs from captured strap");
            a_wide_serdes: assert property (@(posedge hclk) disable iff (!hresetn)
                held && $past(held) && !single_ff[k] |->
                    serdes_pd_ff[k] == port_pd_ff[P])
                else $error("four-lane serdes not following primary port");
            a_wide_override: assert property (@(posedge hclk) disable iff (!hresetn)
                held && $past(held) && !single_ff[k] && $past(wpd_en_ff[k]) |->
                    serdes_pd_ff[k] == $past(wpd_val_ff[k]))
                else $error("wide override ignored");
            a_wide_unused: assert property (@(posedge hclk) disable iff (!hresetn)
                held && $past(held) && !single_ff[k] |->
                    port_pd_ff[P+1] && port_pd_ff[P+8] && port_pd_ff[P+9])
                else $error("secondary port up in four-lane mode");
            a_narrow_port: assert property (@(posedge hclk) disable iff (!hresetn)
                held && $past(held) && single_ff[k] |->
                    port_pd_ff[P+1] == $past(pd_req[P+1]) &&
                    port_pd_ff[P+9] == $past(pd_req[P+9]))
                else $error("secondary port not following own control");
            a_narrow_serdes: assert property (@(posedge hclk) disable iff (!hresetn)
                held && single_ff[k] |-> serdes_pd_ff[k] ==
                    (port_pd_ff[P] & port_pd_ff[P+1] & port_pd_ff[P+8] & port_pd_ff[P+9]))
                else $error("single-lane serdes power-down wrong");
        end
    endgenerate

    // outputs powered down until straps are in
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            single_ff    <= mlps_pkg::MAC_RST;
            port_pd_ff   <= mlps_pkg::PORT_PD_RST;
            serdes_pd_ff <= mlps_pkg::SERDES_PD_RST;
            sampled_ff   <= 1'b0;
        end else if (held) begin
            single_ff    <= eff_mode;
            port_pd_ff   <= nxt_port_pd;
            serdes_pd_ff <= nxt_serdes_pd;
            sampled_ff   <= 1'b1;
        end
    end

    // strap pins drive back their captured level only under test
    logic [MAC_N-1:0]           mode_oe_ff;
    logic [mlps_pkg::PRI_N-1:0] pri_oe_ff;
    logic [mlps_pkg::SEC_N-1:0] sec_oe_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_oe_ff <= '0;
            pri_oe_ff  <= '0;
            sec_oe_ff  <= '0;
        end else begin
            mode_oe_ff <= {MAC_N{test_sync}};
            pri_oe_ff  <= {mlps_pkg::PRI_N{test_sync}};
            sec_oe_ff  <= {mlps_pkg::SEC_N{test_sync}};
        end
    end

    a_pins_input: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(test_sync) |-> (mode_oe_ff == '0) && (pri_oe_ff == '0) && (sec_oe_ff == '0))
        else $error("strap driver enabled outside test mode");
    a_strap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        held && $past(held) |-> $stable(cap_pd_ff) && $stable(cap_mode_ff))
        else $error("captured strap changed after power-up");
    a_capture_once: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(sampled_ff) |-> $past(held) && !$past(held, 2))
        else $error("strap capture timing wrong");

    assign hrdata    = hrdata_ff;
    assign hreadyout = 1'b1 | wr_pend_ff;
    assign hresp     = 1'b0 & wr_pend_ff;

    assign override_a_strap_o                  = cap_mode_pins_ff;
    assign override_a_strap_oe                 = mode_oe_ff;
    assign primary_port_powerdown_strap_o    = cap_pri_ff;
    assign primary_port_powerdown_strap_oe   = pri_oe_ff;
    assign secondary_port_powerdown_strap_o  = cap_sec_ff;
    assign secondary_port_powerdown_strap_oe = sec_oe_ff;
    assign mac_single_lane                   = single_ff;
    assign port_powerdown                    = port_pd_ff;
    assign serdes_powerdown                  = serdes_pd_ff;
    assign powerup_sampled                   = sampled_ff;
endmodule
`default_nettype wire

// File: sim/mlps_board.sv
// board tie-offs on the strap pins of the strap block
// assumes tie values are held by the bench and the dut drives only in test mode
`timescale 1ns/1ps
`default_nettype none
module mlps_board (
    input  wire logic [3:0]  tie_mode,
    input  wire logic [2:0]  tie_pri,
    input  wire logic [11:0] tie_sec,
    input  wire logic [3:0]  mode_o,
    input  wire logic [3:0]  mode_oe,
    input  wire logic [2:0]  pri_o,
    input  wire logic [2:0]  pri_oe,
    input  wire logic [11:0] sec_o,
    input  wire logic [11:0] sec_oe,
    output logic      [3:0]  mode_pin,
    output logic      [2:0]  pri_pin,
    output logic      [11:0] sec_pin
);
    // a driving pad beats the 10k tie-off
    assign mode_pin = (mode_oe & mode_o) | (~mode_oe & tie_mode);
    assign pri_pin  = (pri_oe & pri_o) | (~pri_oe & tie_pri);
    assign sec_pin  = (sec_oe & sec_o) | (~sec_oe & tie_sec);
endmodule
`default_nettype wire

// File: sim/tb_mlps_top.sv
// self-checking bench for mlps_top over its AHB-Lite port
// assumes mlps_board sits on the strap pins; no wait states are assumed
`timescale 1ns/1ps
`default_nettype none
module tb_mlps_top;
    logic        hclk, hresetn, hsel, hwrite, test_mode, hreadyout, hresp, powerup_sampled;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize, tie_pri, pri_pin, pri_o, pri_oe;
    logic [31:0] hwdata, hrdata, q;
    logic [3:0]  tie_mode, mode_pin, mode_o, mode_oe, mac_single_lane, serdes_powerdown;
    logic [11:0] tie_sec, sec_pin, sec_o, sec_oe;
    logic [15:0] port_powerdown;
    int          n_errors, checked, cycles, w;

    mlps_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .test_mode(test_mode),
        .override_a_strap_i(mode_pin), .override_a_strap_o(mode_o), .override_a_strap_oe(mode_oe),
        .primary_port_powerdown_strap_i(pri_pin), .primary_port_powerdown_strap_o(pri_o),
        .primary_port_powerdown_strap_oe(pri_oe), .secondary_port_powerdown_strap_i(sec_pin),
        .secondary_port_powerdown_strap_o(sec_o), .secondary_port_powerdown_strap_oe(sec_oe),
        .mac_single_lane(mac_single_lane), .port_powerdown(port_powerdown),
        .serdes_powerdown(serdes_powerdown), .powerup_sampled(powerup_sampled));

    mlps_board i_board (.tie_mode(tie_mode), .tie_pri(tie_pri), .tie_sec(tie_sec),
        .mode_o(mode_o), .mode_oe(mode_oe), .pri_o(pri_o), .pri_oe(pri_oe), .sec_o(sec_o),
        .sec_oe(sec_oe), .mode_pin(mode_pin), .pri_pin(pri_pin), .sec_pin(sec_pin));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    task automatic stop_test();
        if (n_errors == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        // whole run is under a hundred cycles
        if (cycles == 3000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // entered just after a rising edge; returns at the edge ending the data phase
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= mlps_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= mlps_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // returns {port power-down, serdes power-down} for modes m and requests r
    function automatic logic [19:0] eff(input logic [3:0] m, input logic [15:0] r);
        logic [15:0] p;
        logic [3:0]  s;
        int          x;
        p = r;
        for (int k = 0; k < 4; k++) begin
            x = 2 * k;
            if (m[k]) begin
                s[k] = r[x] & r[x+1] & r[x+8] & r[x+9];
            end else begin
                p[x+1] = 1'b1;
                p[x+8] = 1'b1;
                p[x+9] = 1'b1;
                s[k]   = r[x];
            end
        end
        return {p, s};
    endfunction

    task automatic expect_state(input logic [3:0] m, input logic [15:0] r);
        logic [19:0] e;
        e = eff(m, r);
        repeat (2) @(posedge hclk);
        chk("single_lane", {28'h0, mac_single_lane}, {28'h0, m});
        chk("port_pd", {16'h0, port_powerdown}, {16'h0, e[19:4]});
        chk("serdes_pd", {28'h0, serdes_powerdown}, {28'h0, e[3:0]});
        bus(mlps_pkg::OFF_EFFECT_ST, 1'b0, 32'h0);
        chk("effect_st", q, {e[19:4], 8'h00, e[3:0], m});
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask

    initial begin
        {hsel, hwrite, test_mode, hresetn} = 4'h0;
        {haddr, htrans, hsize, hwdata} = '0;
        tie_mode = 4'h5;
        tie_pri  = 3'h2;
        tie_sec  = 12'h031;
        repeat (4) @(posedge hclk);
        chk("pd_in_reset", {16'h0, port_powerdown}, 32'h0000_FFFF);
        chk("sampled_in_reset", {31'h0, powerup_sampled}, 32'h0);
        hresetn <= 1'b1;
        w = 0;
        while (powerup_sampled !== 1'b1 && w < 20) begin
            @(posedge hclk);
            w++;
        end
        chk("sampled", {31'h0, powerup_sampled}, 32'h1);
        // straps put ports 1, 4, 8, 9 down
        expect_state(4'h5, 16'h0312);
        bus(mlps_pkg::OFF_STRAP_ST, 1'b0, 32'h0);
        chk("strap_st", q, 32'h8003_1205);
        chk("oe_normal", {13'h0, mode_oe, pri_oe, sec_oe}, 32'h0);
        tie_mode <= 4'hA;
        tie_pri  <= 3'h5;
        tie_sec  <= 12'hFCE;
        repeat (6) @(posedge hclk);
        expect_state(4'h5, 16'h0312);
        bus(mlps_pkg::OFF_WIDE_PD, 1'b1, 32'h0000_0101);
        expect_state(4'h5, 16'h0313);
        bus(mlps_pkg::OFF_MODE_CTRL, 1'b1, 32'h0000_0A0F);
        expect_state(4'hA, 16'h0313);
        bus(mlps_pkg::OFF_PORT_PD, 1'b1, 32'hFFFF_FFFF);
        bus(mlps_pkg::OFF_PORT_PD, 1'b0, 32'h0);
        chk("port_pd_reg", q, 32'hFFAA_FFAA);
        expect_state(4'hA, 16'hFFBB);
        bus(8'h20, 1'b1, 32'hFFFF_FFFF);
        bus(8'h20, 1'b0, 32'h0);
        chk("unmapped", q, 32'h0);
        bus(mlps_pkg::OFF_MODE_CTRL, 1'b0, 32'h0);
        chk("mode_ctrl", q, 32'h0000_0A0F);
        test_mode <= 1'b1;
        repeat (4) @(posedge hclk);
        chk("oe_test", {13'h0, mode_oe, pri_oe, sec_oe}, 32'h0007_FFFF);
        chk("o_test", {13'h0, mode_o, pri_o, sec_o}, 32'h0002_A031);
        test_mode <= 1'b0;
        repeat (4) @(posedge hclk);
        chk("oe_back", {13'h0, mode_oe, pri_oe, sec_oe}, 32'h0);
        stop_test();
    end
endmodule
`default_nettype wire
